// >>> rtl/tsa_consts.svh
`ifndef TSA_CONSTS_SVH
`define TSA_CONSTS_SVH

// Register indices; the byte address is four times the index
`define TSA_IDX_TEMP_MSB 6'h00
`define TSA_IDX_TEMP_LSB 6'h01
`define TSA_IDX_STATUS 6'h02
`define TSA_IDX_CONFIG 6'h03
`define TSA_IDX_HIGH_MSB 6'h04
`define TSA_IDX_HIGH_LSB 6'h05
`define TSA_IDX_LOW_MSB 6'h06
`define TSA_IDX_LOW_LSB 6'h07
`define TSA_IDX_CRIT_MSB 6'h08
`define TSA_IDX_CRIT_LSB 6'h09
`define TSA_IDX_HYST 6'h0A
`define TSA_IDX_ID 6'h0B

// Reset values
`define TSA_RST_CONFIG 8'h00
`define TSA_RST_HIGH 16'h2000
`define TSA_RST_LOW 16'h0500
`define TSA_RST_CRIT 16'h4980
`define TSA_RST_HYST 8'h05

// Configuration fields
`define TSA_CFG_FQ_LSB 0
`define TSA_CFG_FQ_MSB 1
`define TSA_CFG_INTMODE 4
`define TSA_CFG_MODE_LSB 5
`define TSA_CFG_MODE_MSB 6
`define TSA_CFG_RES16 7

// Status fields
`define TSA_STAT_LOW 4
`define TSA_STAT_HIGH 5
`define TSA_STAT_CRIT 6
`define TSA_STAT_RDY_N 7

// Hysteresis whole degrees to 16-bit code
`define TSA_HYST_SHIFT 7

// Timing
`define TSA_CLK_HZ 25000000
`define TSA_TICK_US 1000
`define TSA_TICK_CYCLES ((`TSA_CLK_HZ / 1000000) * `TSA_TICK_US)
`define TSA_CONV_MS 240
`define TSA_SPS_CONV_MS 60
`define TSA_SPS_IDLE_MS 940
`define TSA_WAKE_MS 1

`endif

// >>> rtl/tsa_fault_queue.sv
// Purpose: consecutive fault counter qualifying one alarm
// Assumes: conv_end is a one-cycle pulse per finished conversion
// Notes: depth code 0..3 means 1..4 consecutive faults
module tsa_fault_queue
  import tsa_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic hold_clear,
  input wire logic [1:0] depth,
  // Conversion events
  input wire logic conv_end,
  input wire logic fault,
  output logic qualified
);
  logic [1:0] cnt_q;

  // [R11] Qualify on enough consecutive faults
  assign qualified = conv_end && fault && (cnt_q >= depth);

  // [R12] Reset count on clean result
  // [R26] Count per conversion, clear in shutdown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 2'h0;
    end else if (hold_clear) begin
      cnt_q <= 2'h0;
    end else if (conv_end) begin
      if (!fault) begin
        cnt_q <= 2'h0;
      end else if (cnt_q < depth) begin
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end

  a_fault_resets_count: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
    conv_end && !fault && !hold_clear |=> cnt_q == 2'h0)
    else $error("fault count not cleared by clean result");

  a_qual_needs_depth: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
    conv_end && fault && !hold_clear && (cnt_q < depth) |-> !qualified ##1 cnt_q == $past(cnt_q) + 2'h1)
    else $error("alarm qualified before queue depth");

  a_shdn_clears_count: assert property (@(posedge pclk) disable iff (!presetn) // [R26]
    hold_clear |=> cnt_q == 2'h0)
    else $error("fault count kept during shutdown");
endmodule

// >>> rtl/tsa_mode_alarm.sv
// Purpose: conversion mode sequencing, alarm pins, fault queue, result format
// Assumes: adc_code is the converter's 16-bit two's complement code, valid at
//   the end of each conversion; APB slave with registers at index * 4
// Notes: alarm pins are open drain and active low
// How it works
// [R1] Interrupt mode: any read clears both pins
// [R2] Comparator: mode write clears limit within hysteresis
// [R3] Comparator: mode write clears critical below hysteresis
// [R4] Once per second: 60 ms convert, 940 ms idle
// [R5] Mode code 10 selects once-per-second
// [R6] Mode code 11 shuts down, no conversions
// [R7] Mode code 00 leaves shutdown after 1 ms
// [R8] Leaving shutdown starts a conversion at once
// [R9] Shutdown keeps last result readable
// [R10] Config bits 1:0 pick queue depth 1..4
// [R11] Pins fire after enough consecutive faults
// [R12] A clean conversion zeroes the fault count
// [R13] Step 0.0625 in 13-bit, 1/128 in 16-bit
// [R14] Compare with critical, upper high; lower low
// [R15] 13-bit word; bits 2:0 hold event flags
// [R16] 16-bit puts result in bits 2:0; 13-bit default
// [R17] 13-bit result sits in bits 15:3
// [R18] 16-bit code is degrees times 128
// [R19] Host reads high byte then low byte
// [R20] Host drops bits 6:3 for 9-bit
// [R21] One-shot critical pin only after conversion ends
// [R22] Mode code 01 converts once then shuts down
// [R23] Power-up in continuous normal conversion
// [R24] Limit pin any limit; critical pin critical only
// [R25] Config bit 4 picks interrupt or comparator
// [R26] Fault count per conversion, cleared in shutdown
//
// Our own choices: the register offsets and the APB register port.
`include "tsa_consts.svh"

module tsa_mode_alarm
  import tsa_pkg::*;
#(
  parameter int TICK_CYCLES = `TSA_TICK_CYCLES,
  // Identity value is arbitrary
  parameter logic [7:0] ID_VALUE = 8'h5A
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter
  input wire logic [15:0] adc_code,
  output logic adc_run,
  // Limit alarm pin, open drain
  output logic limit_alarm_pin_out,
  output logic limit_alarm_pin_oe,
  // Critical alarm pin, open drain
  output logic critical_alarm_pin_out,
  output logic critical_alarm_pin_oe
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  tsa_state_type state_q, state_d;
  logic [TW-1:0] tick_cnt_q;
  logic [9:0] ms_q, ms_target;
  logic tick, ms_done, restart;
  logic [7:0] cfg_q, hysteresis_value_q, lsb_hold_q, rdata;
  logic [15:0] thigh_q, lower_limit_q, critical_limit_q, temp_q;
  logic [3:0] stat_q;
  logic msb_read_q, pready_q, pslverr_q, adc_run_q, od_level_q;
  logic [31:0] prdata_q;
  logic lim_act_q, crit_act_q;
  logic setup, access, wr_en, rd_en, mapped, mode_wr, conv_end;
  logic [5:0] idx;
  tsa_mode_type mode, new_mode;
  logic res16, int_mode;
  logic signed [16:0] code_s, stored_s, high_s, low_s, crit_s, hyst_s;
  logic fault_hi, fault_lo, fault_cr, within_lim, within_crit;
  logic lim_qual, crit_qual, in_shdn;

  assign mode = tsa_mode_type'(cfg_q[`TSA_CFG_MODE_MSB:`TSA_CFG_MODE_LSB]);
  assign new_mode = tsa_mode_type'(pwdata[`TSA_CFG_MODE_MSB:`TSA_CFG_MODE_LSB]);
  assign res16 = cfg_q[`TSA_CFG_RES16];
  assign int_mode = cfg_q[`TSA_CFG_INTMODE];
  assign in_shdn = (state_q == TSA_ST_SHDN);

  // APB decode
  assign idx = paddr[7:2];
  assign setup = psel && !penable;
  assign access = psel && penable && pready_q;
  assign wr_en = access && pwrite;
  assign rd_en = access && !pwrite;
  assign mode_wr = wr_en && mapped && (idx == `TSA_IDX_CONFIG);

  always_comb begin
    mapped = (paddr[1:0] == 2'h0) && (idx <= `TSA_IDX_ID);
  end

  // [R13] [R16] Mask flag bits in 13-bit resolution
  function automatic logic signed [16:0] fmt(input logic [15:0] v, input logic r16);
    fmt = r16 ? {v[15], v} : {v[15], v[15:3], 3'h0};
  endfunction

  // [R14] Upper and critical high, lower low
  always_comb begin
    code_s = fmt(adc_code, res16);
    stored_s = fmt(temp_q, res16);
    high_s = fmt(thigh_q, res16);
    low_s = fmt(lower_limit_q, res16);
    crit_s = fmt(critical_limit_q, res16);
    hyst_s = {6'h00, hysteresis_value_q[3:0], 7'h00};
    fault_hi = code_s > high_s;
    fault_lo = code_s < low_s;
    fault_cr = code_s > crit_s;
    within_lim = (stored_s < high_s - hyst_s) && (stored_s > low_s + hyst_s);
    within_crit = stored_s < crit_s - hyst_s;
  end

  // Millisecond tick divider, realigned on each state entry
  assign tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));
  // Reaching or passing the target ends the phase, so a shorter target set mid-phase cannot wrap
  assign ms_done = tick && (ms_q >= ms_target - 10'h001);
  assign conv_end = (state_q == TSA_ST_CONV) && ms_done;

  always_comb begin
    ms_target = 10'(`TSA_CONV_MS);
    case (state_q)
      // [R4] Short conversion in once-per-second mode
      TSA_ST_CONV: ms_target = (mode == TSA_MODE_SPS) ? 10'(`TSA_SPS_CONV_MS) : 10'(`TSA_CONV_MS);
      TSA_ST_IDLE: ms_target = 10'(`TSA_SPS_IDLE_MS);
      TSA_ST_WAKE: ms_target = 10'(`TSA_WAKE_MS);
      default: ms_target = 10'(`TSA_CONV_MS);
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= '0;
      ms_q <= 10'h000;
    end else if (restart || in_shdn) begin
      tick_cnt_q <= '0;
      ms_q <= 10'h000;
    end else if (tick) begin
      tick_cnt_q <= '0;
      ms_q <= ms_q + 10'h001;
    end else begin
      tick_cnt_q <= tick_cnt_q + TW'(1);
    end
  end

  // Mode sequencer
  always_comb begin
    state_d = state_q;
    if (mode_wr) begin
      case (new_mode)
        // [R6] Shut down at once
        TSA_MODE_SHDN: state_d = TSA_ST_SHDN;
        // [R22] Start a single conversion
        TSA_MODE_ONESHOT: state_d = TSA_ST_CONV;
        // [R7] [R5] Leave shutdown through the wake delay
        default: state_d = in_shdn ? TSA_ST_WAKE : state_q;
      endcase
    end else begin
      case (state_q)
        TSA_ST_CONV: begin
          if (ms_done) begin
            // [R23] [R4] [R22] Next step per mode
            case (mode)
              TSA_MODE_NORMAL: state_d = TSA_ST_CONV;
              TSA_MODE_SPS: state_d = TSA_ST_IDLE;
              default: state_d = TSA_ST_SHDN;
            endcase
          end
        end
        TSA_ST_IDLE: begin
          if (ms_done) begin
            state_d = TSA_ST_CONV;
          end
        end
        TSA_ST_WAKE: begin
          // [R8] Conversion right after wake
          if (ms_done) begin
            state_d = TSA_ST_CONV;
          end
        end
        default: state_d = TSA_ST_SHDN;
      endcase
    end
  end

  assign restart = (state_d != state_q) || ms_done || (mode_wr && new_mode == TSA_MODE_ONESHOT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= TSA_ST_CONV;
      adc_run_q <= 1'b1;
    end else begin
      state_q <= state_d;
      adc_run_q <= (state_d == TSA_ST_CONV);
    end
  end

  // [R9] Result only changes at conversion end
  // [R15] [R17] [R16] [R18] Result word layout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_q <= 16'h0000;
    end else if (conv_end) begin
      temp_q <= res16 ? adc_code : {adc_code[15:3], fault_cr, fault_hi, fault_lo};
    end
  end

  // Configuration and setpoint registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= `TSA_RST_CONFIG;
      thigh_q <= `TSA_RST_HIGH;
      lower_limit_q <= `TSA_RST_LOW;
      critical_limit_q <= `TSA_RST_CRIT;
      hysteresis_value_q <= `TSA_RST_HYST;
    end else if (wr_en && mapped) begin
      if (idx == `TSA_IDX_CONFIG) begin
        cfg_q <= pwdata[7:0];
      end else if (idx == `TSA_IDX_HIGH_MSB) begin
        thigh_q[15:8] <= pwdata[7:0];
      end else if (idx == `TSA_IDX_HIGH_LSB) begin
        thigh_q[7:0] <= pwdata[7:0];
      end else if (idx == `TSA_IDX_LOW_MSB) begin
        lower_limit_q[15:8] <= pwdata[7:0];
      end else if (idx == `TSA_IDX_LOW_LSB) begin
        lower_limit_q[7:0] <= pwdata[7:0];
      end else if (idx == `TSA_IDX_CRIT_MSB) begin
        critical_limit_q[15:8] <= pwdata[7:0];
      end else if (idx == `TSA_IDX_CRIT_LSB) begin
        critical_limit_q[7:0] <= pwdata[7:0];
      end else if (idx == `TSA_IDX_HYST) begin
        hysteresis_value_q <= pwdata[7:0];
      end
    end
  end

  // Status: ready flag and sticky event flags, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 4'h8;
    end else begin
      if (conv_end) begin
        stat_q[3] <= 1'b0;
      end else if ((rd_en && mapped && idx <= `TSA_IDX_TEMP_LSB) ||
                   (mode_wr && (mode == TSA_MODE_ONESHOT || mode == TSA_MODE_SPS))) begin
        stat_q[3] <= 1'b1;
      end
      if (conv_end && (fault_cr || fault_hi || fault_lo)) begin
        stat_q[2:0] <= stat_q[2:0] | {fault_cr, fault_hi, fault_lo};
      end else if (rd_en && mapped && idx == `TSA_IDX_STATUS) begin
        stat_q[2:0] <= 3'h0;
      end
    end
  end

  // Low byte is frozen when the high byte is read, keeping the pair coherent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lsb_hold_q <= 8'h00;
      msb_read_q <= 1'b0;
    end else if (rd_en && mapped && idx == `TSA_IDX_TEMP_MSB) begin
      lsb_hold_q <= temp_q[7:0];
      msb_read_q <= 1'b1;
    end else if (rd_en) begin
      msb_read_q <= 1'b0;
    end
  end

  // Read mux
  always_comb begin
    rdata = 8'h00;
    if (idx == `TSA_IDX_TEMP_MSB) begin
      rdata = temp_q[15:8];
    end else if (idx == `TSA_IDX_TEMP_LSB) begin
      rdata = msb_read_q ? lsb_hold_q : temp_q[7:0];
    end else if (idx == `TSA_IDX_STATUS) begin
      rdata = {stat_q, 4'h0};
    end else if (idx == `TSA_IDX_CONFIG) begin
      rdata = cfg_q;
    end else if (idx == `TSA_IDX_HIGH_MSB) begin
      rdata = thigh_q[15:8];
    end else if (idx == `TSA_IDX_HIGH_LSB) begin
      rdata = thigh_q[7:0];
    end else if (idx == `TSA_IDX_LOW_MSB) begin
      rdata = lower_limit_q[15:8];
    end else if (idx == `TSA_IDX_LOW_LSB) begin
      rdata = lower_limit_q[7:0];
    end else if (idx == `TSA_IDX_CRIT_MSB) begin
      rdata = critical_limit_q[15:8];
    end else if (idx == `TSA_IDX_CRIT_LSB) begin
      rdata = critical_limit_q[7:0];
    end else if (idx == `TSA_IDX_HYST) begin
      rdata = hysteresis_value_q;
    end else if (idx == `TSA_IDX_ID) begin
      rdata = ID_VALUE;
    end
  end

  // Zero-wait answer prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= !mapped;
        prdata_q <= (mapped && !pwrite) ? {24'h000000, rdata} : 32'h00000000;
      end
    end
  end

  // [R10] Queue depth from config bits 1:0
  // [R24] Limit queue sees any limit, critical queue only critical
  tsa_fault_queue u_lim_queue (
    .pclk(pclk),
    .presetn(presetn),
    .hold_clear(in_shdn),
    .depth(cfg_q[`TSA_CFG_FQ_MSB:`TSA_CFG_FQ_LSB]),
    .conv_end(conv_end),
    .fault(fault_hi || fault_lo || fault_cr),
    .qualified(lim_qual)
  );

  tsa_fault_queue u_crit_queue (
    .pclk(pclk),
    .presetn(presetn),
    .hold_clear(in_shdn),
    .depth(cfg_q[`TSA_CFG_FQ_MSB:`TSA_CFG_FQ_LSB]),
    .conv_end(conv_end),
    .fault(fault_cr),
    .qualified(crit_qual)
  );

  // [R25] Interrupt or comparator clear, qualified set wins
  // [R1] [R2] [R3] Clear conditions per mode
  // [R21] Pins only set at conversion end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lim_act_q <= 1'b0;
      crit_act_q <= 1'b0;
    end else begin
      if (lim_qual) begin
        lim_act_q <= 1'b1;
      end else if (int_mode ? rd_en : (mode_wr && within_lim)) begin
        lim_act_q <= 1'b0;
      end
      if (crit_qual) begin
        crit_act_q <= 1'b1;
      end else if (int_mode ? rd_en : (mode_wr && within_crit)) begin
        crit_act_q <= 1'b0;
      end
    end
  end

  // Open drain never drives high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      od_level_q <= 1'b0;
    end else begin
      od_level_q <= 1'b0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign adc_run = adc_run_q;
  assign limit_alarm_pin_out = od_level_q;
  assign limit_alarm_pin_oe = lim_act_q;
  assign critical_alarm_pin_out = od_level_q;
  assign critical_alarm_pin_oe = crit_act_q;

  a_int_read_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    int_mode && rd_en && !lim_qual && !crit_qual |=> !lim_act_q && !crit_act_q)
    else $error("interrupt mode read left a pin active");

  a_cmp_limit_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    !int_mode && mode_wr && within_lim && !lim_qual |=> !lim_act_q)
    else $error("comparator mode write did not clear limit pin");

  a_cmp_crit_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    !int_mode && mode_wr && within_crit && !crit_qual |=> !crit_act_q)
    else $error("comparator mode write did not clear critical pin");

  a_sps_idle_after: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    conv_end && mode == TSA_MODE_SPS && !mode_wr |=> state_q == TSA_ST_IDLE && !adc_run)
    else $error("once per second mode did not idle after conversion");

  a_shdn_no_conv: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    in_shdn && !mode_wr |=> !adc_run && in_shdn)
    else $error("conversion ran during shutdown");

  a_wake_starts_conv: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
    state_q == TSA_ST_WAKE && ms_done && !mode_wr |=> state_q == TSA_ST_CONV && adc_run)
    else $error("no conversion after leaving shutdown");

  a_shdn_keeps_result: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
    in_shdn |=> $stable(temp_q))
    else $error("result changed during shutdown");

  a_flags_in_result: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
    conv_end && !res16 |=> temp_q[2:0] == {$past(fault_cr), $past(fault_hi), $past(fault_lo)})
    else $error("13-bit result flags wrong");

  a_result_16bit: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
    conv_end && res16 |=> temp_q == $past(adc_code))
    else $error("16-bit result not stored whole");

  a_oneshot_shdn: assert property (@(posedge pclk) disable iff (!presetn) // [R22]
    conv_end && mode == TSA_MODE_ONESHOT && !mode_wr |=> in_shdn)
    else $error("one-shot did not shut down after conversion");

  a_crit_set_only_end: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
    $rose(crit_act_q) |-> $past(conv_end) && $past(fault_cr))
    else $error("critical pin rose outside a conversion end");

  c_int_clear: cover property (@(posedge pclk) disable iff (!presetn)
    int_mode && lim_act_q ##1 rd_en ##1 !lim_act_q);
  c_oneshot: cover property (@(posedge pclk) disable iff (!presetn)
    mode == TSA_MODE_ONESHOT && conv_end ##1 in_shdn);
  c_sps_idle: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == TSA_ST_IDLE && ms_done);
  c_wake: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == TSA_ST_WAKE ##1 state_q == TSA_ST_CONV);
endmodule

// >>> rtl/tsa_pkg.sv
// Purpose: types for the sensor mode and alarm logic
// Assumes: constants live in tsa_consts.svh
// Notes: state codes are Gray along the usual path
package tsa_pkg;
  typedef enum logic [1:0] {
    TSA_MODE_NORMAL = 2'h0,
    TSA_MODE_ONESHOT = 2'h1,
    TSA_MODE_SPS = 2'h2,
    TSA_MODE_SHDN = 2'h3
  } tsa_mode_type;

  typedef enum logic [1:0] {
    TSA_ST_CONV = 2'h0,
    TSA_ST_IDLE = 2'h1,
    TSA_ST_SHDN = 2'h3,
    TSA_ST_WAKE = 2'h2
  } tsa_state_type;
endpackage

// >>> test/tb_temp_sensor_mode_alarm_logic.sv
// Purpose: self-checking bench for the mode and alarm block
// Assumes: TICK_CYCLES shortened to 4, so one conversion is 960 cycles
// Notes: conversions are phased by a one-shot write followed by the wanted mode
module tb_temp_sensor_mode_alarm_logic import tsa_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int T = 4;
  localparam int CONV = 240 * T;
  localparam logic [15:0] COLD = 16'h0C80;
  localparam logic [15:0] HOT = 16'h2100;
  localparam logic [15:0] CRIT = 16'h4A00;
  localparam logic [5:0] FQ_HOT = 6'b111011;
  localparam logic [7:0] RSTV [8] = '{8'h00, 8'h20, 8'h00, 8'h05, 8'h00, 8'h49, 8'h80, 8'h05};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, adc_run, errv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv, rdl;
  logic [15:0] adc_code, temp_code;
  logic lim_out, lim_oe, crit_out, crit_oe;
  int err_count, checks_done, hi, lo;

  tsa_mode_alarm #(.TICK_CYCLES(T)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .adc_code(adc_code), .adc_run(adc_run),
    .limit_alarm_pin_out(lim_out), .limit_alarm_pin_oe(lim_oe),
    .critical_alarm_pin_out(crit_out), .critical_alarm_pin_oe(crit_oe));
  tsa_adc_model u_adc (.adc_run(adc_run), .temp_code(temp_code), .adc_code(adc_code));

  always #20 pclk = ~pclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] wd,
      output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    n = 1;
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) chk(32'h0, 32'h1);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, idx, 8'h00, d, e);
    chk(d, {24'h0, exp});
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask

  // Restart a conversion now, then continue in the wanted mode
  task automatic start(input logic [7:0] cfg);
    wr(6'h03, cfg | 8'h20);
    wr(6'h03, cfg);
  endtask

  task automatic pins(input logic [1:0] exp);
    @(negedge pclk);
    chk({30'h0, crit_oe, lim_oe}, {30'h0, exp});
    @(posedge pclk);
  endtask

  task automatic run_is(input logic exp);
    @(negedge pclk);
    chk({31'h0, adc_run}, {31'h0, exp});
    @(posedge pclk);
  endtask

  task automatic span(input logic lvl, output int n);
    n = 0;
    while (adc_run === lvl && n < 5000) begin
      @(negedge pclk);
      n++;
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge pclk);
    err_count++;
    conclude();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    temp_code = COLD;
    err_count = 0;
    checks_done = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    run_is(1'b1);
    for (int i = 0; i < 8; i++) rd(6'(3 + i), RSTV[i]);
    // Plain 13-bit result
    start(8'h00);
    repeat (CONV + 20) @(posedge pclk);
    rd(6'h00, 8'h0C);
    rd(6'h01, 8'h80);
    apb(1'b0, 6'h00, 8'h00, rdv, errv);
    apb(1'b0, 6'h01, 8'h00, rdl, errv);
    chk({23'h0, rdv[7:0], rdl[7]}, 32'h19);
    // Three-deep queue broken by one clean conversion
    for (int k = 0; k < 6; k++) begin
      temp_code <= FQ_HOT[k] ? HOT : COLD;
      if (k == 0) start(8'h02);
      repeat (k == 0 ? CONV + 20 : CONV) @(posedge pclk);
      pins({1'b0, k == 5});
      if (k == 0) rd(6'h01, 8'h02);
    end
    temp_code <= COLD;
    repeat (CONV) @(posedge pclk);
    wr(6'h03, 8'h02);
    pins(2'b00);
    // Interrupt mode, cleared by any read
    temp_code <= CRIT;
    start(8'h10);
    repeat (CONV + 20) @(posedge pclk);
    pins(2'b11);
    apb(1'b0, 6'h0C, 8'h00, rdv, errv);
    chk({rdv[30:0], errv}, 32'h1);
    pins(2'b00);
    // One-shot, then shutdown
    wr(6'h03, 8'h20);
    repeat (CONV - 20) @(posedge pclk);
    pins(2'b00);
    repeat (40) @(posedge pclk);
    pins(2'b11);
    run_is(1'b0);
    repeat (2 * CONV) @(posedge pclk);
    run_is(1'b0);
    rd(6'h00, 8'h4A);
    temp_code <= COLD;
    wr(6'h03, 8'h20);
    repeat (CONV + 20) @(posedge pclk);
    wr(6'h03, 8'h60);
    pins(2'b00);
    repeat (2 * CONV) @(posedge pclk);
    run_is(1'b0);
    rd(6'h00, 8'h0C);
    // Wake into 16-bit normal mode
    temp_code <= 16'hFB05;
    wr(6'h03, 8'h80);
    run_is(1'b0);
    repeat (2 * T + 4) @(posedge pclk);
    run_is(1'b1);
    repeat (CONV + 20) @(posedge pclk);
    rd(6'h00, 8'hFB);
    rd(6'h01, 8'h05);
    // Once per second timing
    wr(6'h03, 8'h40);
    repeat (2 * CONV) @(negedge pclk);
    span(1'b1, hi);
    span(1'b0, lo);
    span(1'b1, hi);
    span(1'b0, lo);
    chk(hi, 60 * T);
    chk(lo, 940 * T);
    chk({31'h0, lim_out | crit_out}, 32'h0);
    conclude();
  end
endmodule

// >>> test/tsa_adc_model.sv
// Purpose: converter stand-in that supplies the sensed code
// Assumes: the design samples adc_code while adc_run is still high
// Notes: outside a run the code is inverted so a late sample shows
module tsa_adc_model
  import tsa_pkg::*;
(
  // Control from design
  input wire logic adc_run,
  // Temperature from the bench
  input wire logic [15:0] temp_code,
  // Code to design
  output logic [15:0] adc_code
);
  timeunit 1ns;
  timeprecision 1ns;
  assign adc_code = adc_run ? temp_code : ~temp_code;
endmodule
